// ==== count_clock_source.sv ====
// Count pulse source: event pin edge detection or prescaler tap selection.
module count_clock_source (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] code,
  input wire logic oscillation_mode_bit,
  input wire logic event_pin,
  input wire logic [dual_timer_pkg::PRESCALER_WIDTH-1:0] tap_ones,
  output logic count_pulse
);

  logic sync_a;
  logic sync_b;
  logic sync_prev;

  // Edge detection only looks at the second synchroniser stage.
  wire rise = sync_b & ~sync_prev;
  wire fall = ~sync_b & sync_prev;
  wire in_div = (code >= dual_timer_pkg::CODE_DIV_FIRST) &&
                (code <= dual_timer_pkg::CODE_DIV_LAST);
  wire [3:0] base_index = (code == dual_timer_pkg::CODE_DIV_TOP) ?
                          dual_timer_pkg::TOP_TAP_INDEX : code - dual_timer_pkg::CODE_DIV_FIRST;
  // Half-rate base moves every tap one stage further down.
  wire [3:0] tap_index = base_index + {3'h0, ~oscillation_mode_bit}; // see [RQ5]
  wire tap_hit = tap_ones[tap_index];
  wire next_count_pulse = (code == dual_timer_pkg::CODE_FALLING_EDGE) ? fall : // see [RQ3]
                          (code == dual_timer_pkg::CODE_RISING_EDGE) ? rise :
                          (in_div || code == dual_timer_pkg::CODE_DIV_TOP) ? tap_hit :
                          1'b0;

  // Synchronise the pin and register the selected pulse.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_prev <= 1'b0;
      count_pulse <= 1'b0;
    end else begin
      sync_a <= event_pin; // see [RQ18]
      sync_b <= sync_a;
      sync_prev <= sync_b;
      count_pulse <= next_count_pulse;
    end
  end

  a_rising_edge_pulse: assert property (@(posedge core_clk) disable iff (rst) // see [RQ18]
    (code == dual_timer_pkg::CODE_RISING_EDGE && sync_b && !sync_prev) |=> count_pulse)
    else $error("Rising edge did not give a count pulse.");

  a_prohibited_code_quiet: assert property (@(posedge core_clk) disable iff (rst) // see [RQ3]
    (code inside {4'h2, 4'h3, 4'h4, 4'h5, 4'hE}) |=> !count_pulse)
    else $error("Prohibited code produced a count pulse.");

endmodule

// ==== dual_timer_control.sv ====
// Clock selection, mode, output control and port direction for two 8-bit counters.
// Summary of operation
// [RQ1] Count clock select register sits at FF41H, read/write, reset to 00H.
// [RQ2] Software writes the count clock select register with byte writes only.
// [RQ3] Low nibble picks first counter clock: pin edges or prescaler taps.
// [RQ4] High nibble picks second counter clock the same way with its own pin.
// [RQ5] Prescaler base is full rate with mode bit 1, half rate with 0.
// [RQ6] Software stops counting before rewriting the clock select register.
// [RQ7] Mode control starts, stops and sets cascade mode; reset to 00H.
// [RQ8] Mode, output control and port direction take bit and byte writes.
// [RQ9] Software changes operating mode only while counting is stopped.
// [RQ10] In cascade mode only the first run enable starts the 16-bit counter.
// [RQ11] Output control sets and clears level flops, inversion and pin enable.
// [RQ12] Two set/reset level flops exist, one per counter output.
// [RQ13] Level set and clear bits are strobes and always read back 0.
// [RQ14] Software writes output control only while counting is stopped.
// [RQ15] Port direction sets each pin direction, reset FFH meaning all inputs.
// [RQ16] Software clears direction bits and port latches to drive timer outputs.
// [RQ17] On compare match the counter clears, keeps counting and raises interrupt.
// [RQ18] Event pins are synchronised and give one count pulse per chosen edge.
module dual_timer_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire dual_timer_pkg::cpu_req_t cpu_req,
  output logic [7:0] rd_data,
  input wire logic oscillation_mode_bit,
  input wire logic first_event_input,
  input wire logic second_event_input,
  output logic first_timer_output,
  output logic first_timer_oe,
  output logic second_timer_output,
  output logic second_timer_oe,
  output logic first_match_irq,
  output logic second_match_irq,
  output logic [7:0] port_direction
);

  // ********************************************************************
  // Registers and decode.
  // ********************************************************************
  logic [7:0] count_clock_select;
  logic [7:0] mode_control;
  logic [7:0] output_control;
  logic [7:0] first_compare;
  logic [7:0] second_compare;
  logic [7:0] first_counter;
  logic [7:0] second_counter;
  logic first_level_flop;
  logic second_level_flop;
  logic [dual_timer_pkg::PRESCALER_WIDTH-1:0] prescaler;
  logic [dual_timer_pkg::PRESCALER_WIDTH-1:0] tap_ones;
  logic first_pulse;
  logic second_pulse;

  wire byte_wr = cpu_req.wr & ~cpu_req.bit_op;
  wire sel_ccs = cpu_req.addr == dual_timer_pkg::ADDR_COUNT_CLOCK_SELECT;
  wire sel_mode = cpu_req.addr == dual_timer_pkg::ADDR_MODE_CONTROL;
  wire sel_outc = cpu_req.addr == dual_timer_pkg::ADDR_OUTPUT_CONTROL;
  wire sel_pdir = cpu_req.addr == dual_timer_pkg::ADDR_PORT_DIRECTION;
  wire sel_cmp1 = cpu_req.addr == dual_timer_pkg::ADDR_FIRST_COMPARE;
  wire sel_cmp2 = cpu_req.addr == dual_timer_pkg::ADDR_SECOND_COMPARE;
  wire sel_cnt1 = cpu_req.addr == dual_timer_pkg::ADDR_FIRST_COUNTER;
  wire sel_cnt2 = cpu_req.addr == dual_timer_pkg::ADDR_SECOND_COUNTER;

  // Merges a byte or single-bit write into the old register value.
  function automatic logic [7:0] merge_write(input logic [7:0] old_value,
                                             input dual_timer_pkg::cpu_req_t req);
    logic [7:0] result;
    result = old_value;
    if (req.bit_op) begin
      result[req.bit_sel] = req.bit_val;
    end else begin
      result = req.wdata;
    end
    return result;
  endfunction

  wire [7:0] next_mode_control = merge_write(mode_control, cpu_req); // see [RQ8]
  wire [7:0] outc_written = merge_write(output_control, cpu_req);
  wire [7:0] next_port_direction = merge_write(port_direction, cpu_req);
  wire outc_wr = cpu_req.wr & sel_outc;
  wire [7:0] level_strobe = outc_wr ? (outc_written & dual_timer_pkg::LEVEL_STROBE_MASK) : 8'h00;
  wire [7:0] next_output_control = outc_written & ~dual_timer_pkg::LEVEL_STROBE_MASK; // see [RQ13]

  wire [7:0] next_rd_data = sel_ccs ? count_clock_select :
                            sel_mode ? mode_control :
                            sel_outc ? output_control :
                            sel_pdir ? port_direction :
                            sel_cmp1 ? first_compare :
                            sel_cmp2 ? second_compare :
                            sel_cnt1 ? first_counter :
                            sel_cnt2 ? second_counter : dual_timer_pkg::READ_UNMAPPED;

  // Register writes; clock select ignores bit writes, strobe bits never stick.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_clock_select <= dual_timer_pkg::COUNT_CLOCK_SELECT_RESET; // see [RQ1]
      mode_control <= dual_timer_pkg::MODE_CONTROL_RESET; // see [RQ7]
      output_control <= dual_timer_pkg::OUTPUT_CONTROL_RESET; // see [RQ11]
      port_direction <= dual_timer_pkg::PORT_DIRECTION_RESET; // see [RQ15]
      first_compare <= dual_timer_pkg::COMPARE_RESET;
      second_compare <= dual_timer_pkg::COMPARE_RESET;
      rd_data <= dual_timer_pkg::READ_UNMAPPED;
    end else begin
      if (byte_wr && sel_ccs) count_clock_select <= cpu_req.wdata; // see [RQ1] [RQ2]
      if (cpu_req.wr && sel_mode) mode_control <= next_mode_control; // see [RQ8]
      if (outc_wr) output_control <= next_output_control; // see [RQ13]
      if (cpu_req.wr && sel_pdir) port_direction <= next_port_direction; // see [RQ15]
      if (byte_wr && sel_cmp1) first_compare <= cpu_req.wdata;
      if (byte_wr && sel_cmp2) second_compare <= cpu_req.wdata;
      if (cpu_req.rd) rd_data <= next_rd_data;
    end
  end

  // ********************************************************************
  // Prescaler and count clock selection.
  // ********************************************************************
  // Free-running divider of the main clock.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescaler <= dual_timer_pkg::PRESCALER_RESET;
    end else begin
      prescaler <= prescaler + 12'h001;
    end
  end

  // Tap j is high one cycle in every 2^(j+1) cycles.
  genvar j;
  for (j = 0; j < dual_timer_pkg::PRESCALER_WIDTH; j++) begin : g_tap
    assign tap_ones[j] = &prescaler[j:0];
  end

  count_clock_source first_source (
    .core_clk(core_clk),
    .rst(rst),
    .code(count_clock_select[3:0]), // see [RQ3]
    .oscillation_mode_bit(oscillation_mode_bit),
    .event_pin(first_event_input),
    .tap_ones(tap_ones),
    .count_pulse(first_pulse)
  );

  count_clock_source second_source (
    .core_clk(core_clk),
    .rst(rst),
    .code(count_clock_select[7:4]), // see [RQ4]
    .oscillation_mode_bit(oscillation_mode_bit),
    .event_pin(second_event_input),
    .tap_ones(tap_ones),
    .count_pulse(second_pulse)
  );

  // ********************************************************************
  // Counters, compare match and cascade.
  // ********************************************************************
  wire cascade = mode_control[dual_timer_pkg::CASCADE_MODE_BIT];
  wire first_run = mode_control[dual_timer_pkg::FIRST_RUN_ENABLE_BIT];
  // The second run enable is ignored while cascaded.
  wire second_run = mode_control[dual_timer_pkg::SECOND_RUN_ENABLE_BIT] & ~cascade; // see [RQ10]
  wire first_hit = first_pulse & first_run;
  wire second_hit = second_pulse & second_run;
  wire [15:0] wide_count = {second_counter, first_counter};
  wire wide_match = wide_count == {second_compare, first_compare};
  wire [15:0] wide_next = wide_match ? 16'h0000 : wide_count + 16'h0001;
  wire first_event = ~cascade & first_hit & (first_counter == first_compare);
  wire second_event = cascade ? (first_hit & wide_match) :
                      (second_hit & (second_counter == second_compare));

  // Match clears the counter and counting carries on; stopping clears it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      first_counter <= dual_timer_pkg::COUNTER_RESET;
      second_counter <= dual_timer_pkg::COUNTER_RESET;
      first_match_irq <= 1'b0;
      second_match_irq <= 1'b0;
    end else begin
      first_match_irq <= first_event; // see [RQ17]
      second_match_irq <= second_event;
      if (cascade) begin
        if (!first_run) begin
          first_counter <= dual_timer_pkg::COUNTER_RESET;
          second_counter <= dual_timer_pkg::COUNTER_RESET;
        end else if (first_hit) begin
          {second_counter, first_counter} <= wide_next; // see [RQ10] [RQ17]
        end
      end else begin
        if (!first_run) first_counter <= dual_timer_pkg::COUNTER_RESET;
        else if (first_hit) first_counter <= first_event ? 8'h00 : first_counter + 8'h01;
        if (!second_run) second_counter <= dual_timer_pkg::COUNTER_RESET;
        else if (second_hit) second_counter <= second_event ? 8'h00 : second_counter + 8'h01;
      end
    end
  end

  // ********************************************************************
  // Output control circuits.
  // ********************************************************************
  wire first_invert = output_control[dual_timer_pkg::FIRST_INVERT_ENABLE_BIT];
  wire second_invert = output_control[dual_timer_pkg::SECOND_INVERT_ENABLE_BIT];

  // Level flops: software set or clear wins over a match toggle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      first_level_flop <= 1'b0;
      second_level_flop <= 1'b0;
      first_timer_output <= 1'b0;
      second_timer_output <= 1'b0;
      first_timer_oe <= 1'b0;
      second_timer_oe <= 1'b0;
    end else begin
      if (level_strobe[dual_timer_pkg::FIRST_LEVEL_SET_BIT]) first_level_flop <= 1'b1;
      else if (level_strobe[dual_timer_pkg::FIRST_LEVEL_CLEAR_BIT]) first_level_flop <= 1'b0;
      else if (first_event && first_invert) first_level_flop <= ~first_level_flop; // see [RQ12]
      if (level_strobe[dual_timer_pkg::SECOND_LEVEL_SET_BIT]) second_level_flop <= 1'b1;
      else if (level_strobe[dual_timer_pkg::SECOND_LEVEL_CLEAR_BIT]) second_level_flop <= 1'b0;
      else if (second_event && second_invert) second_level_flop <= ~second_level_flop;
      first_timer_output <= first_level_flop;
      second_timer_output <= second_level_flop;
      // Pin is driven only when output is enabled and the pin is an output.
      first_timer_oe <= output_control[dual_timer_pkg::FIRST_OUTPUT_ENABLE_BIT] & // see [RQ11]
                        ~port_direction[dual_timer_pkg::PIN1_DIRECTION_BIT]; // see [RQ16]
      second_timer_oe <= output_control[dual_timer_pkg::SECOND_OUTPUT_ENABLE_BIT] &
                         ~port_direction[dual_timer_pkg::PIN2_DIRECTION_BIT];
    end
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_values: assert property (@(posedge core_clk) disable iff (1'b0) // see [RQ1] [RQ15]
    rst |=> (count_clock_select == 8'h00 && port_direction == 8'hFF && mode_control == 8'h00))
    else $error("Register reset values wrong.");

  a_ccs_bit_ignored: assert property ( // see [RQ2]
    (cpu_req.wr && cpu_req.bit_op && sel_ccs) |=> $stable(count_clock_select))
    else $error("Bit write changed the clock select register.");

  a_strobe_reads_zero: assert property ( // see [RQ13]
    outc_wr |=> (output_control & 8'h33) == 8'h00)
    else $error("Level strobe bits did not read back zero.");

  a_level_set_takes: assert property ( // see [RQ12]
    (outc_wr && outc_written[1]) |=> first_level_flop ##1 first_timer_output)
    else $error("First level set did not reach the output.");

  a_match_clears: assert property ( // see [RQ17]
    first_event |=> (first_counter == 8'h00 && first_match_irq))
    else $error("Match did not clear the first counter and raise its interrupt.");

  a_cascade_second_idle: assert property ( // see [RQ10]
    (cascade && !first_run) |=> (wide_count == 16'h0000 && !second_match_irq))
    else $error("Cascaded counter ran without the first run enable.");

  a_mode_bit_write: assert property ( // see [RQ7] [RQ8]
    (cpu_req.wr && cpu_req.bit_op && sel_mode) |=>
      mode_control[$past(cpu_req.bit_sel)] == $past(cpu_req.bit_val))
    else $error("Bit write to mode control not applied.");

  a_pin_enable: assert property ( // see [RQ16]
    port_direction[1] |=> !first_timer_oe)
    else $error("Timer pin driven while configured as input.");

endmodule

// ==== dual_timer_control_tb_top.sv ====
// Self-checking testbench for the dual timer clock and control block.
module dual_timer_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************************************************
  // Clock, stimulus signals and the design under test.
  // ********************************************************************
  logic core_clk;
  logic rst;
  dual_timer_pkg::cpu_req_t cpu_req;
  logic oscillation_mode_bit;
  logic first_event_input;
  logic second_event_input;
  logic [7:0] rd_data;
  logic first_timer_output, first_timer_oe, second_timer_output, second_timer_oe;
  logic first_match_irq, second_match_irq;
  logic [7:0] port_direction;
  // Pin levels and drive enables of both timer outputs, gathered for comparison.
  wire [3:0] pin_state = {first_timer_output, first_timer_oe, second_timer_output, second_timer_oe};
  logic [31:0] seed;
  int n_fail;
  int total_checks;
  int n_irq1;
  int n_irq2;

  dual_timer_control i_dual_timer_control (
    .core_clk(core_clk),
    .rst(rst),
    .cpu_req(cpu_req),
    .rd_data(rd_data),
    .oscillation_mode_bit(oscillation_mode_bit),
    .first_event_input(first_event_input),
    .second_event_input(second_event_input),
    .first_timer_output(first_timer_output),
    .first_timer_oe(first_timer_oe),
    .second_timer_output(second_timer_output),
    .second_timer_oe(second_timer_oe),
    .first_match_irq(first_match_irq),
    .second_match_irq(second_match_irq),
    .port_direction(port_direction)
  );

  // The clock runs at 125 MHz.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Counts the interrupt pulses of both counters, one per sampled high cycle.
  always @(posedge core_clk) begin
    if (first_match_irq === 1'b1) n_irq1++;
    if (second_match_irq === 1'b1) n_irq2++;
  end

  // ********************************************************************
  // Expectation functions and random source.
  // ********************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Cycles between two match pulses for a prescaler code, mode bit and compare value.
  function automatic int interval_cycles(input logic [3:0] code, input logic mode, input int cmp);
    int k;
    k = (code == dual_timer_pkg::CODE_DIV_TOP) ? 11 : int'(code) - 5;
    return (cmp + 1) << (k + (mode ? 0 : 1));
  endfunction

  // The level set and clear strobes always read back as zero.
  function automatic logic [7:0] read_mask(input logic [15:0] addr);
    return (addr == dual_timer_pkg::ADDR_OUTPUT_CONTROL) ?
           ~dual_timer_pkg::LEVEL_STROBE_MASK : 8'hFF;
  endfunction

  // ********************************************************************
  // Tasks for comparisons, bus cycles and interval measurement.
  // ********************************************************************
  task automatic next_rand(output logic [7:0] r);
    seed = xorshift(seed);
    r = seed[7:0];
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One bus request, held for one clock edge, then released.
  task automatic bus(input logic [15:0] addr, input logic wr, input logic bit_op,
                     input logic [2:0] bsel, input logic bval, input logic [7:0] wdata);
    @(posedge core_clk);
    #1;
    cpu_req.addr = addr;
    cpu_req.wr = wr;
    cpu_req.rd = ~wr;
    cpu_req.bit_op = bit_op;
    cpu_req.bit_sel = bsel;
    cpu_req.bit_val = bval;
    cpu_req.wdata = wdata;
    @(posedge core_clk);
    #1;
    cpu_req.wr = 1'b0;
    cpu_req.rd = 1'b0;
  endtask

  task automatic wr8(input logic [15:0] addr, input logic [7:0] data);
    bus(addr, 1'b1, 1'b0, 3'h0, 1'b0, data);
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp);
    bus(addr, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00);
    check(rd_data, exp);
  endtask

  // Waits for a match pulse, then counts the cycles up to the next one.
  task automatic measure(input bit sel, output int per);
    int n;
    n = 0;
    per = 0;
    while (((sel ? second_match_irq : first_match_irq) !== 1'b1) && n < 20000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    do begin
      @(posedge core_clk);
      #1;
      per++;
    end while (((sel ? second_match_irq : first_match_irq) !== 1'b1) && per < 20000);
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cuts a hang short at 75,000 cycles, well beyond the at most 40,000 or so the tests take.
  initial begin
    #600000;
    n_fail++;
    give_verdict;
  end

  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial begin
    logic [7:0] r;
    logic [7:0] b;
    logic [15:0] addr;
    int per;
    logic [3:0] bad [5];
    bad = '{4'h2, 4'h3, 4'h4, 4'h5, 4'hE};
    seed = 32'h4B47;
    n_fail = 0;
    total_checks = 0;
    cpu_req = '0;
    oscillation_mode_bit = 1'b1;
    first_event_input = 1'b0;
    second_event_input = 1'b0;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    // Reset values and an unmapped read.
    check(port_direction, dual_timer_pkg::PORT_DIRECTION_RESET);
    rd_chk(dual_timer_pkg::ADDR_COUNT_CLOCK_SELECT, 8'h00);
    rd_chk(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h00);
    rd_chk(dual_timer_pkg::ADDR_OUTPUT_CONTROL, 8'h00);
    rd_chk(dual_timer_pkg::ADDR_PORT_DIRECTION, 8'hFF);
    rd_chk(16'hFF40, dual_timer_pkg::READ_UNMAPPED);
    // Byte write then single-bit write to each control register; run bits stay clear.
    for (int i = 0; i < 4; i++) begin
      addr = dual_timer_pkg::ADDR_COUNT_CLOCK_SELECT + 16'(i);
      next_rand(r);
      next_rand(b);
      if (i == 1) r = r & 8'hF8;
      if (i == 1) b[2] = 1'b1;
      wr8(addr, r);
      rd_chk(addr, r & read_mask(addr));
      bus(addr, 1'b1, 1'b1, b[2:0], ~r[b[2:0]], 8'h00);
      if (i != 0) r[b[2:0]] = ~r[b[2:0]];
      rd_chk(addr, r & read_mask(addr));
    end
    check(port_direction, r);
    // Level flops set and cleared, pin drive follows enable and direction.
    wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h00);
    wr8(dual_timer_pkg::ADDR_PORT_DIRECTION, 8'hF9);
    // Sets the first flop and clears the second, whatever the random writes left in it.
    wr8(dual_timer_pkg::ADDR_OUTPUT_CONTROL, 8'h9A);
    repeat (2) @(posedge core_clk);
    #1;
    check(pin_state, 4'hD);
    wr8(dual_timer_pkg::ADDR_OUTPUT_CONTROL, 8'hA9);
    repeat (2) @(posedge core_clk);
    #1;
    check(pin_state, 4'h7);
    bus(dual_timer_pkg::ADDR_PORT_DIRECTION, 1'b1, 1'b1, 3'h1, 1'b1, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    check(pin_state, 4'h3);
    // Every prescaler code in both oscillation modes, random compare values except 0 for code F.
    for (int m = 0; m < 2; m++) begin
      for (int c = 6; c < 16; c++) begin
        if (c == 14) continue;
        wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h00);
        oscillation_mode_bit = m[0];
        next_rand(r);
        next_rand(b);
        r = (c == 15) ? 8'h00 : r % 8'h03;
        b = (c == 15) ? 8'h00 : b % 8'h03;
        wr8(dual_timer_pkg::ADDR_FIRST_COMPARE, r);
        wr8(dual_timer_pkg::ADDR_SECOND_COMPARE, b);
        wr8(dual_timer_pkg::ADDR_COUNT_CLOCK_SELECT, {c[3:0], c[3:0]});
        wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h03);
        measure(1'b0, per);
        check(per, interval_cycles(c[3:0], m[0], int'(r)));
        measure(1'b1, per);
        check(per, interval_cycles(c[3:0], m[0], int'(b)));
      end
    end
    // Prohibited codes give no count pulses.
    foreach (bad[j]) begin
      wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h00);
      wr8(dual_timer_pkg::ADDR_COUNT_CLOCK_SELECT, {bad[j], bad[j]});
      wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h03);
      n_irq1 = 0;
      n_irq2 = 0;
      repeat (300) @(posedge core_clk);
      #1;
      check(n_irq1 + n_irq2, 0);
    end
    // Event pins: first counts falling edges, second counts rising edges.
    wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h00);
    wr8(dual_timer_pkg::ADDR_COUNT_CLOCK_SELECT, 8'h10);
    // Inversion on: two falls leave the first flop at 0, three rises take the second to 0.
    wr8(dual_timer_pkg::ADDR_OUTPUT_CONTROL, 8'h44);
    wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h03);
    n_irq1 = 0;
    n_irq2 = 0;
    for (int i = 0; i < 5; i++) begin
      next_rand(r);
      repeat (6 + int'(r[1:0])) @(posedge core_clk);
      #1;
      first_event_input = ~first_event_input;
      second_event_input = ~second_event_input;
    end
    repeat (10) @(posedge core_clk);
    #1;
    check(n_irq1, 2);
    check(n_irq2, 3);
    check({first_timer_output, second_timer_output}, 2'h0);
    // Cascade: the second run bit alone does nothing, the first runs 16 bits.
    wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h00);
    oscillation_mode_bit = 1'b1;
    wr8(dual_timer_pkg::ADDR_COUNT_CLOCK_SELECT, 8'h66);
    wr8(dual_timer_pkg::ADDR_FIRST_COMPARE, 8'h02);
    wr8(dual_timer_pkg::ADDR_SECOND_COMPARE, 8'h01);
    wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h06);
    n_irq1 = 0;
    n_irq2 = 0;
    repeat (600) @(posedge core_clk);
    #1;
    check(n_irq1 + n_irq2, 0);
    wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h05);
    measure(1'b1, per);
    check(per, interval_cycles(4'h6, 1'b1, 258));
    check(n_irq1, 0);
    wr8(dual_timer_pkg::ADDR_MODE_CONTROL, 8'h00);
    rd_chk(dual_timer_pkg::ADDR_FIRST_COUNTER, dual_timer_pkg::COUNTER_RESET);
    give_verdict;
  end
endmodule

// ==== dual_timer_pkg.sv ====
// Shared constants and types for the dual timer clock and control block.
package dual_timer_pkg;

  // ********************************************************************
  // Register addresses and reset values.
  // ********************************************************************
  localparam logic [15:0] ADDR_COUNT_CLOCK_SELECT = 16'hFF41;
  localparam logic [15:0] ADDR_MODE_CONTROL = 16'hFF42;
  localparam logic [15:0] ADDR_OUTPUT_CONTROL = 16'hFF43;
  localparam logic [15:0] ADDR_PORT_DIRECTION = 16'hFF44;
  localparam logic [15:0] ADDR_FIRST_COMPARE = 16'hFF45;
  localparam logic [15:0] ADDR_SECOND_COMPARE = 16'hFF46;
  localparam logic [15:0] ADDR_FIRST_COUNTER = 16'hFF47;
  localparam logic [15:0] ADDR_SECOND_COUNTER = 16'hFF48;

  localparam logic [7:0] COUNT_CLOCK_SELECT_RESET = 8'h00;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int FIRST_RUN_ENABLE_BIT = 0;
  localparam int SECOND_RUN_ENABLE_BIT = 1;
  localparam int CASCADE_MODE_BIT = 2;
  localparam int FIRST_LEVEL_CLEAR_BIT = 0;
  localparam int FIRST_LEVEL_SET_BIT = 1;
  localparam int FIRST_INVERT_ENABLE_BIT = 2;
  localparam int FIRST_OUTPUT_ENABLE_BIT = 3;
  localparam int SECOND_LEVEL_CLEAR_BIT = 4;
  localparam int SECOND_LEVEL_SET_BIT = 5;
  localparam int SECOND_INVERT_ENABLE_BIT = 6;
  localparam int SECOND_OUTPUT_ENABLE_BIT = 7;
  localparam int PIN1_DIRECTION_BIT = 1;
  localparam int PIN2_DIRECTION_BIT = 2;
  localparam logic [7:0] LEVEL_STROBE_MASK = 8'h33;

  // ********************************************************************
  // Count clock codes and prescaler shape.
  // ********************************************************************
  localparam logic [3:0] CODE_FALLING_EDGE = 4'h0;
  localparam logic [3:0] CODE_RISING_EDGE = 4'h1;
  localparam logic [3:0] CODE_DIV_FIRST = 4'h6;
  localparam logic [3:0] CODE_DIV_LAST = 4'hD;
  localparam logic [3:0] CODE_DIV_TOP = 4'hF;
  localparam logic [3:0] TOP_TAP_INDEX = 4'hA;
  localparam int PRESCALER_WIDTH = 12;
  localparam logic [PRESCALER_WIDTH-1:0] PRESCALER_RESET = 12'h000;

  // CPU data memory access, byte or single bit.
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic bit_op;
    logic [2:0] bit_sel;
    logic bit_val;
    logic [7:0] wdata;
  } cpu_req_t;

endpackage
